//--- pkg/tpm_map.svh
// Offsets, field positions, reset values and timing counts of the mode/status block
`ifndef TPM_MAP_SVH
`define TPM_MAP_SVH

// Core clock rate
`define TPM_CLK_MHZ             250

// Times in their own units
`define TPM_JABBER_MIN_MS       20
`define TPM_JABBER_OFF_MS       600
`define TPM_LINK_LOSS_MS        100
`define TPM_BLINK_MS            50
`define TPM_SQE_NS              1000

// Derived cycle counts (least times, exact at this rate)
`define TPM_MS_CYCLES(ms)       ((ms) * `TPM_CLK_MHZ * 1000)
`define TPM_SQE_CYCLES          ((`TPM_SQE_NS * `TPM_CLK_MHZ) / 1000)

// Test register width
`define TPM_TEST_W              8

// Register byte offsets
`define TPM_CTRL_OFS            8'h00
`define TPM_STATUS_OFS          8'h04
`define TPM_TEST_OFS            8'h08

// Control fields and reset value
`define TPM_CTRL_SQE_INHIBIT    0
`define TPM_CTRL_LINK_LED_EN    1
`define TPM_CTRL_RESET          32'h0000_0002

// Status fields
`define TPM_ST_MODE_LO          0
`define TPM_ST_JABBER           2
`define TPM_ST_LINK_OK          3
`define TPM_ST_SQUELCH_OPEN     4
`define TPM_ST_COLLISION        5
`define TPM_ST_LOOPBACK         6
`define TPM_ST_FULL_DUPLEX      7

// Bus responses
`define TPM_RESP_OKAY           2'h0
`define TPM_RESP_SLVERR         2'h2

`endif

//--- pkg/tpm_pkg.sv
// Types shared by the mode/status block, its assertions and its bench
package tpm_pkg;

    // Operating mode, Gray coded along the test-entry path
    typedef enum logic [1:0] {
        TPM_NORMAL     = 2'h0,
        TPM_LOOP_ARMED = 2'h1,
        TPM_TEST_RESET = 2'h3,
        TPM_TEST       = 2'h2
    } tpm_mode_t;

    // Register bus request, master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } tpm_axi_req_t;

    // Register bus response, slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tpm_axi_rsp_t;

    // Qualified state of the receive line from the analog front end
    typedef struct packed {
        logic rx_data;
        logic rx_active;
        logic link_pulse;
        logic squelch_open;
    } tpm_line_t;

endpackage : tpm_pkg

//--- hw/tpm_test_reg.sv
// Serial test-selection register loaded from the quality-test pin
`timescale 1ns/10ps

module tpm_test_reg #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Serial load
    input  wire logic             i_shift,
    input  wire logic             i_data,
    // Parallel view
    output      logic [WIDTH-1:0] o_value
);

    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] value_d;

    // New bits enter at the bottom, oldest leaves at the top
    assign value_d = i_shift ? {value_q[WIDTH-2:0], i_data} : value_q;

    // Cleared by the block reset as well as by the device reset
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            value_q <= '0;
        end else begin
            value_q <= value_d;
        end
    end

    assign o_value = value_q;

endmodule : tpm_test_reg

//--- hw/tpm_mode_status.sv
// Mode control, status indicators and register slave of the twisted-pair attachment unit
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "tpm_map.svh"

module tpm_mode_status #(
    parameter int unsigned JABBER_CYCLES = `TPM_MS_CYCLES(`TPM_JABBER_MIN_MS),
    parameter int unsigned JAB_OFF_CYCLES = `TPM_MS_CYCLES(`TPM_JABBER_OFF_MS),
    parameter int unsigned LINK_LOSS_CYCLES = `TPM_MS_CYCLES(`TPM_LINK_LOSS_MS),
    parameter int unsigned BLINK_CYCLES = `TPM_MS_CYCLES(`TPM_BLINK_MS)
) (
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_n,
    // Register bus
    input  wire tpm_pkg::tpm_axi_req_t i_axi,
    output      tpm_pkg::tpm_axi_rsp_t o_axi,
    // Controller-side inputs
    input  wire logic                  i_full_duplex_select_n,
    input  wire logic                  i_loop_back_select_n,
    input  wire logic                  i_quality_test_enable_n,
    input  wire logic                  i_transmit_enable_in,
    input  wire logic                  i_transmit_serial_in,
    input  wire logic                  i_crystal_clock_in,
    // Analog front end
    input  wire tpm_pkg::tpm_line_t    i_line,
    output      logic                  o_line_driver_enable,
    output      logic                  o_line_tx_data,
    // Controller-side outputs
    output      logic                  o_buffered_clock_out,
    output      logic                  o_collision_indicator,
    output      logic                  o_jabber_indicator,
    output      logic                  o_squelch_status,
    output      logic                  o_received_serial_out,
    output      logic                  o_link_status,
    output      logic                  o_link_status_oe_n,
    output      logic                  o_device_reset
);

    // Picks one line of an eight-line status group
    function automatic logic pick8(input logic [7:0] lines, input logic [2:0] sel);
        pick8 = lines[sel];
    endfunction : pick8

    // Register decode, shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == `TPM_CTRL_OFS) || (addr == `TPM_STATUS_OFS) ||
                    (addr == `TPM_TEST_OFS);
    endfunction : is_mapped

    // Sampled controller pins
    logic              full_n_q;
    logic              loop_n_q;
    logic              qual_n_q;
    logic              tx_en_q;
    logic              tx_ser_q;
    logic              xtal_q;
    // Mode machine
    tpm_pkg::tpm_mode_t mode_q;
    tpm_pkg::tpm_mode_t mode_d;
    // Jabber, quality test and link timers
    logic [31:0]       tx_cnt_q;
    logic [31:0]       off_cnt_q;
    logic              jab_q;
    logic              txoff_seen_q;
    logic [15:0]       sqe_cnt_q;
    logic [31:0]       link_cnt_q;
    logic              link_ok_q;
    logic [31:0]       blink_cnt_q;
    logic              blink_q;
    // Software control
    logic [31:0]       ctrl_q;
    // Register bus state
    tpm_pkg::tpm_axi_rsp_t rsp_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [7:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    // Output flops
    logic              coll_out_q;
    logic              jab_out_q;
    logic              sq_out_q;
    logic              rx_out_q;
    logic              link_out_q;
    logic              link_oe_n_q;
    logic              drv_en_q;
    logic              drv_data_q;
    logic              clk_out_q;
    logic              dev_rst_q;

    // Mode decode
    wire test_mode  = (mode_q == tpm_pkg::TPM_TEST);
    wire dev_rst    = dev_rst_q;
    wire func_rst_n = i_rst_n & ~dev_rst;
    wire normal_op  = (mode_q == tpm_pkg::TPM_NORMAL) || (mode_q == tpm_pkg::TPM_LOOP_ARMED);
    wire loopback   = normal_op & ~loop_n_q;
    wire full_dup   = normal_op & ~full_n_q;
    wire xtal_rise  = i_crystal_clock_in & ~xtal_q;
    wire any_sel_hi = loop_n_q | full_n_q;

    // Pins sample once; reset value high so a floating select stays inactive
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            full_n_q <= 1'b1;
            loop_n_q <= 1'b1;
            qual_n_q <= 1'b1;
            tx_en_q  <= 1'b0;
            tx_ser_q <= 1'b1;
            xtal_q   <= 1'b0;
        end else begin
            full_n_q <= i_full_duplex_select_n;
            loop_n_q <= i_loop_back_select_n;
            qual_n_q <= i_quality_test_enable_n;
            tx_en_q  <= i_transmit_enable_in;
            tx_ser_q <= i_transmit_serial_in;
            xtal_q   <= i_crystal_clock_in;
        end
    end

    // Test entry needs loop-back low strictly before full duplex
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            tpm_pkg::TPM_NORMAL: begin
                if (!loop_n_q && full_n_q) begin
                    mode_d = tpm_pkg::TPM_LOOP_ARMED;
                end
            end
            tpm_pkg::TPM_LOOP_ARMED: begin
                if (loop_n_q) begin
                    mode_d = tpm_pkg::TPM_NORMAL;
                end else if (!full_n_q) begin
                    mode_d = tpm_pkg::TPM_TEST_RESET;
                end
            end
            tpm_pkg::TPM_TEST_RESET: begin
                mode_d = any_sel_hi ? tpm_pkg::TPM_NORMAL : tpm_pkg::TPM_TEST;
            end
            tpm_pkg::TPM_TEST: begin
                if (any_sel_hi) begin
                    mode_d = tpm_pkg::TPM_NORMAL;
                end
            end
            default: begin
                mode_d = tpm_pkg::TPM_NORMAL;
            end
        endcase
    end

    // Mode register; not cleared by the device reset it causes
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mode_q <= tpm_pkg::TPM_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
        dev_rst_q <= i_rst_n && (mode_d == tpm_pkg::TPM_TEST_RESET);
    end

    // Test register, clocked by the slow crystal edge while in test mode
    logic [`TPM_TEST_W-1:0] test_val;
    tpm_test_reg #(
        .WIDTH   (`TPM_TEST_W)
    ) u_test_reg (
        .i_clock (i_clock),
        .i_rst_n (func_rst_n),
        .i_shift (test_mode & xtal_rise),
        .i_data  (qual_n_q),
        .o_value (test_val)
    );

    // Jabber timing: length of the current transmission and lockout time
    wire tx_long   = tx_en_q && (tx_cnt_q >= JABBER_CYCLES - 32'h1);
    wire off_done  = (off_cnt_q >= JAB_OFF_CYCLES - 32'h1);
    wire jab_clear = jab_q & off_done & (txoff_seen_q | ~tx_en_q);

    // Counters saturate so a stuck enable cannot wrap and re-arm
    always_ff @(posedge i_clock) begin
        if (!func_rst_n) begin
            tx_cnt_q     <= 32'h0000_0000;
            off_cnt_q    <= 32'h0000_0000;
            jab_q        <= 1'b0;
            txoff_seen_q <= 1'b0;
        end else begin
            tx_cnt_q <= !tx_en_q ? 32'h0000_0000 :
                        (&tx_cnt_q) ? tx_cnt_q : tx_cnt_q + 32'h1;
            if (jab_clear) begin
                jab_q        <= 1'b0;
                off_cnt_q    <= 32'h0000_0000;
                txoff_seen_q <= 1'b0;
            end else if (jab_q) begin
                off_cnt_q    <= off_done ? off_cnt_q : off_cnt_q + 32'h1;
                txoff_seen_q <= txoff_seen_q | ~tx_en_q;
            end else if (tx_long) begin
                jab_q <= 1'b1;
            end
        end
    end

    // Quality test pulse after a clean end of transmission
    wire tx_end    = ~i_transmit_enable_in & tx_en_q;
    wire sqe_on    = (sqe_cnt_q != 16'h0000);
    wire sqe_allow = ~qual_n_q & ~ctrl_q[`TPM_CTRL_SQE_INHIBIT] & ~jab_q & ~full_dup;

    always_ff @(posedge i_clock) begin
        if (!func_rst_n) begin
            sqe_cnt_q <= 16'h0000;
        end else if (tx_end && sqe_allow && !test_mode) begin
            sqe_cnt_q <= 16'(`TPM_SQE_CYCLES);
        end else if (sqe_on) begin
            sqe_cnt_q <= sqe_cnt_q - 16'h0001;
        end
    end

    // Link monitor: any pulse or data restarts the loss timer
    wire link_seen   = i_line.link_pulse | i_line.squelch_open;
    wire link_expire = (link_cnt_q >= LINK_LOSS_CYCLES - 32'h1);
    wire receiving   = link_ok_q & i_line.squelch_open;
    wire blink_wrap  = (blink_cnt_q >= BLINK_CYCLES - 32'h1);

    always_ff @(posedge i_clock) begin
        if (!func_rst_n) begin
            link_cnt_q  <= 32'h0000_0000;
            link_ok_q   <= 1'b0;
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= 1'b0;
        end else begin
            if (link_seen) begin
                link_cnt_q <= 32'h0000_0000;
                link_ok_q  <= 1'b1;
            end else if (link_expire) begin
                link_ok_q  <= 1'b0;
            end else begin
                link_cnt_q <= link_cnt_q + 32'h1;
            end
            // Blink starts with a high phase at each new packet
            if (!receiving) begin
                blink_cnt_q <= 32'h0000_0000;
                blink_q     <= 1'b1;
            end else if (blink_wrap) begin
                blink_cnt_q <= 32'h0000_0000;
                blink_q     <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    // Indicator sources
    // no collision in full duplex
    wire coll_raw   = tx_en_q & i_line.rx_active & ~full_dup & ~loopback;
    wire [7:0] status_lines = {i_line.squelch_open, link_ok_q, i_line.rx_active,
                               i_line.link_pulse, tx_en_q, jab_q, coll_raw, sqe_on};
    wire [7:0] timer_lines  = {off_cnt_q[20], off_cnt_q[10], tx_cnt_q[20], tx_cnt_q[10],
                               link_cnt_q[20], link_cnt_q[10], blink_cnt_q[10], off_done};
    wire coll_d     = test_mode ? pick8(status_lines, test_val[2:0]) : (coll_raw | sqe_on);
    wire jab_ind_d  = test_mode ? pick8(timer_lines, test_val[5:3]) : jab_q;
    wire drv_en_d   = tx_en_q & ~jab_q & ~loopback & normal_op;
    wire rx_out_d   = loopback ? (tx_en_q ? tx_ser_q : 1'b1) :
                      (i_line.squelch_open ? i_line.rx_data : 1'b1);
    // blink while receiving; steady low on pulses only
    wire link_d     = receiving & blink_q;
    wire link_oe_n_d = ~link_ok_q | ~ctrl_q[`TPM_CTRL_LINK_LED_EN];

    // Every pin leaves from a flop; the clock copy costs one cycle of skew
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            coll_out_q  <= 1'b0;
            jab_out_q   <= 1'b0;
            sq_out_q    <= 1'b0;
            rx_out_q    <= 1'b1;
            link_out_q  <= 1'b0;
            link_oe_n_q <= 1'b1;
            drv_en_q    <= 1'b0;
            drv_data_q  <= 1'b1;
            clk_out_q   <= 1'b0;
        end else begin
            coll_out_q  <= coll_d;
            jab_out_q   <= jab_ind_d;
            sq_out_q    <= i_line.squelch_open;
            rx_out_q    <= rx_out_d;
            link_out_q  <= link_d;
            link_oe_n_q <= link_oe_n_d;
            drv_en_q    <= drv_en_d;
            drv_data_q  <= tx_ser_q;
            clk_out_q   <= i_crystal_clock_in;
        end
    end

    // Register bus handshakes
    wire aw_hs    = i_axi.awvalid & rsp_q.awready;
    wire w_hs     = i_axi.wvalid & rsp_q.wready;
    wire ar_hs    = i_axi.arvalid & rsp_q.arready;
    wire do_write = aw_got_q & w_got_q & ~rsp_q.bvalid;
    wire aw_d     = ~do_write & (aw_got_q | aw_hs);
    wire w_d      = ~do_write & (w_got_q | w_hs);
    wire bvalid_d = do_write | (rsp_q.bvalid & ~i_axi.bready);
    wire rvalid_d = ar_hs | (rsp_q.rvalid & ~i_axi.rready);
    wire ctrl_wr  = do_write & (awaddr_q == `TPM_CTRL_OFS);

    // Read mux; unused status and test bits read as zero, all 32 control bits read back as written
    wire [31:0] status_word = {24'h00_0000, full_dup, loopback, coll_out_q,
                               i_line.squelch_open, link_ok_q, jab_q, mode_q};
    wire [31:0] rd_word = (i_axi.araddr == `TPM_CTRL_OFS)   ? ctrl_q :
                          (i_axi.araddr == `TPM_STATUS_OFS) ? status_word :
                          (i_axi.araddr == `TPM_TEST_OFS)   ? {24'h00_0000, test_val} :
                          32'h0000_0000;

    // Byte-lane merge into the control word
    wire [31:0] ctrl_d = {wstrb_q[3] ? wdata_q[31:24] : ctrl_q[31:24],
                          wstrb_q[2] ? wdata_q[23:16] : ctrl_q[23:16],
                          wstrb_q[1] ? wdata_q[15:8]  : ctrl_q[15:8],
                          wstrb_q[0] ? wdata_q[7:0]   : ctrl_q[7:0]};

    // One write and one read in flight; readies drop until the answer is taken
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rsp_q    <= '0;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            ctrl_q   <= `TPM_CTRL_RESET;
        end else begin
            aw_got_q      <= aw_d;
            w_got_q       <= w_d;
            rsp_q.awready <= ~aw_d & ~bvalid_d;
            rsp_q.wready  <= ~w_d & ~bvalid_d;
            rsp_q.bvalid  <= bvalid_d;
            rsp_q.arready <= ~rvalid_d;
            rsp_q.rvalid  <= rvalid_d;
            if (aw_hs) begin
                awaddr_q <= i_axi.awaddr;
            end
            if (w_hs) begin
                wdata_q <= i_axi.wdata;
                wstrb_q <= i_axi.wstrb;
            end
            if (do_write) begin
                rsp_q.bresp <= is_mapped(awaddr_q) ? `TPM_RESP_OKAY : `TPM_RESP_SLVERR;
            end
            if (ctrl_wr) begin
                ctrl_q <= ctrl_d;
            end
            if (ar_hs) begin
                rsp_q.rdata <= rd_word;
                rsp_q.rresp <= is_mapped(i_axi.araddr) ? `TPM_RESP_OKAY : `TPM_RESP_SLVERR;
            end
        end
    end

    // Pin drive
    assign o_axi                 = rsp_q;
    assign o_buffered_clock_out  = clk_out_q;
    assign o_collision_indicator = coll_out_q;
    assign o_jabber_indicator    = jab_out_q;
    assign o_squelch_status      = sq_out_q;
    assign o_received_serial_out = rx_out_q;
    assign o_link_status         = link_out_q;
    assign o_link_status_oe_n    = link_oe_n_q;
    assign o_line_driver_enable  = drv_en_q;
    assign o_line_tx_data        = drv_data_q;

    // Device reset pin, own flop
    assign o_device_reset        = dev_rst;

endmodule : tpm_mode_status

//--- tb/tpm_ctl_model.sv
// Controller-side partner: select pins and crystal clock
`timescale 1ns/10ps

module tpm_ctl_model (
    // Clock, reset and requests
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_test_req,
    input  wire logic i_loop_req,
    input  wire logic i_fd_req,
    // Pins toward the block
    output      logic o_full_duplex_select_n,
    output      logic o_loop_back_select_n,
    output      logic o_crystal_clock_in
);
    logic [4:0] xtal_q;
    logic [1:0] step_q;
    // Free-running 100 ns crystal, 25 core cycles
    always_ff @(posedge i_clock) begin
        xtal_q <= (!i_rst_n || xtal_q == 5'h18) ? 5'h00 : xtal_q + 5'h01;
    end
    assign o_crystal_clock_in = xtal_q < 5'h0C;
    // Entry steps; loop drops two edges before full duplex
    always_ff @(posedge i_clock) begin
        step_q <= (!i_rst_n || !i_test_req) ? 2'h0 : step_q + {1'b0, step_q != 2'h3};
    end
    // Released selects rest high, as pull-ups hold them
    assign o_loop_back_select_n = !(i_loop_req || step_q != 2'h0);
    assign o_full_duplex_select_n = !(i_fd_req || step_q == 2'h3);
endmodule : tpm_ctl_model

//--- tb/tpm_mode_status_sva.sv
// Port assertions for the mode/status block
`timescale 1ns/10ps

module tpm_mode_status_sva #(
    parameter int unsigned JABBER_CYCLES = 40
) (
    // Clock and reset
    input wire logic               i_clock,
    input wire logic               i_rst_n,
    // Inputs
    input wire logic               i_full_duplex_select_n,
    input wire logic               i_loop_back_select_n,
    input wire logic               i_transmit_enable_in,
    input wire logic               i_crystal_clock_in,
    input wire tpm_pkg::tpm_line_t i_line,
    // Outputs
    input wire logic               o_line_driver_enable,
    input wire logic               o_buffered_clock_out,
    input wire logic               o_collision_indicator,
    input wire logic               o_jabber_indicator,
    input wire logic               o_squelch_status,
    input wire logic               o_device_reset
);
    logic [15:0] tx_cnt_q;
    logic [9:0]  fd_cnt_q;
    wire         norm = i_full_duplex_select_n && i_loop_back_select_n;
    wire         fdx  = !i_full_duplex_select_n && i_loop_back_select_n;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // Run lengths; saturating so a long run stays flagged
    always_ff @(posedge i_clock) begin
        tx_cnt_q <= (i_rst_n && i_transmit_enable_in && norm) ? tx_cnt_q + {15'h0, ~&tx_cnt_q} : 16'h0;
        fd_cnt_q <= (i_rst_n && fdx) ? fd_cnt_q + {9'h0, ~&fd_cnt_q} : 10'h0;
    end

    clk_copy_a: assert property ($past(i_rst_n) |->
        o_buffered_clock_out == $past(i_crystal_clock_in)) else $error("clock copy wrong");
    squelch_copy_a: assert property ($past(i_rst_n) |->
        o_squelch_status == $past(i_line.squelch_open)) else $error("squelch status wrong");
    loop_drv_off_a: assert property (!i_loop_back_select_n [*2] |=>
        !o_line_driver_enable) else $error("driver on in loop-back");
    coll_seen_a: assert property ((i_transmit_enable_in && i_line.rx_active && norm
        && tx_cnt_q < JABBER_CYCLES) [*4] |-> o_collision_indicator) else $error("no collision");
    fd_quiet_a: assert property (fd_cnt_q >= 10'h104 |-> !o_collision_indicator)
        else $error("collision in full duplex");
    jab_cut_a: assert property (tx_cnt_q >= JABBER_CYCLES + 3 |->
        o_jabber_indicator && !o_line_driver_enable) else $error("jabber not cut");
    test_entry_a: assert property (o_device_reset |-> (!$past(i_full_duplex_select_n)
        && !$past(i_loop_back_select_n, 2)) ##1 !o_device_reset) else $error("bad reset pulse");
    sel_quiet_a: assert property (i_full_duplex_select_n || i_loop_back_select_n |=>
        !o_device_reset) else $error("reset pulse with a select high");

    // Main scenarios reached
    cover property (o_device_reset);
    cover property (o_jabber_indicator);
    cover property (o_collision_indicator && norm);
endmodule : tpm_mode_status_sva

bind tpm_mode_status tpm_mode_status_sva #(.JABBER_CYCLES(JABBER_CYCLES)) sva_u (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_full_duplex_select_n(i_full_duplex_select_n),
    .i_loop_back_select_n(i_loop_back_select_n), .i_transmit_enable_in(i_transmit_enable_in),
    .i_crystal_clock_in(i_crystal_clock_in), .i_line(i_line),
    .o_line_driver_enable(o_line_driver_enable), .o_buffered_clock_out(o_buffered_clock_out),
    .o_collision_indicator(o_collision_indicator), .o_jabber_indicator(o_jabber_indicator),
    .o_squelch_status(o_squelch_status), .o_device_reset(o_device_reset));

//--- tb/tpm_mode_status_bench.sv
// Self-checking bench for the mode/status block
`timescale 1ns/10ps
`include "tpm_map.svh"

module tpm_mode_status_bench;
    localparam int unsigned JAB  = 40;
    localparam int unsigned JOFF = 100;
    localparam int unsigned LOSS = 60;
    logic i_clock, i_rst_n, qual_n, tx_en, tx_dat, test_req, loop_req, fd_req;
    logic fd_n, lb_n, xtal, drv, txd, clk_o, coll, jab, sq, rxo, link, oe_n, drst;
    logic [31:0] rd, d;
    logic [1:0] resp;
    int mismatches, n_checks, n_rst;
    tpm_pkg::tpm_axi_req_t axi;
    tpm_pkg::tpm_axi_rsp_t rsp;
    tpm_pkg::tpm_line_t line;

    tpm_ctl_model ctl_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_test_req(test_req),
        .i_loop_req(loop_req), .i_fd_req(fd_req), .o_full_duplex_select_n(fd_n),
        .o_loop_back_select_n(lb_n), .o_crystal_clock_in(xtal));
    tpm_mode_status #(.JABBER_CYCLES(JAB), .JAB_OFF_CYCLES(JOFF), .LINK_LOSS_CYCLES(LOSS),
        .BLINK_CYCLES(8)) dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_axi(axi),
        .o_axi(rsp), .i_full_duplex_select_n(fd_n), .i_loop_back_select_n(lb_n),
        .i_quality_test_enable_n(qual_n), .i_transmit_enable_in(tx_en),
        .i_transmit_serial_in(tx_dat), .i_crystal_clock_in(xtal), .i_line(line),
        .o_line_driver_enable(drv), .o_line_tx_data(txd), .o_buffered_clock_out(clk_o),
        .o_collision_indicator(coll), .o_jabber_indicator(jab), .o_squelch_status(sq),
        .o_received_serial_out(rxo), .o_link_status(link), .o_link_status_oe_n(oe_n),
        .o_device_reset(drst));

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    // Count test-entry reset pulses
    always @(posedge i_clock) begin
        if (drst === 1'b1) n_rst <= n_rst + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    // Sample a little after the edge so flop updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : settle

    // One bus write or read; a stuck slave ends the run
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clock);
        if (w) {axi.awvalid, axi.awaddr, axi.wvalid, axi.wdata, axi.bready} <= {1'b1, a, 1'b1, wd, 1'b1};
        else {axi.arvalid, axi.araddr, axi.rready} <= {1'b1, a, 1'b1};
        for (int k = 0; k < 100; k++) begin
            @(posedge i_clock);
            if (rsp.awready) axi.awvalid <= 1'b0;
            if (rsp.wready) axi.wvalid <= 1'b0;
            if (rsp.arready) axi.arvalid <= 1'b0;
            if (w ? rsp.bvalid : rsp.rvalid) begin
                {axi.bready, axi.rready} <= 2'h0;
                resp = w ? rsp.bresp : rsp.rresp;
                rd = rsp.rdata;
                return;
            end
        end
        mismatches++;
        test_done();
    endtask : bus

    initial begin
        void'($urandom(32'hA373));
        {i_rst_n, qual_n, tx_en, tx_dat, test_req, loop_req, fd_req} = '0;
        axi = '0;
        line = '0;
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        axi.wstrb <= 4'hF;
        settle(1);
        check({oe_n, rxo, drst}, 3'h6);
        bus(1'b0, `TPM_CTRL_OFS, 32'h0);
        check(rd, `TPM_CTRL_RESET);
        d = $urandom & 32'hFFFF_FFFC | 32'h2;
        bus(1'b1, `TPM_CTRL_OFS, d);
        bus(1'b0, `TPM_CTRL_OFS, 32'h0);
        check(rd, d);
        bus(1'b0, 8'h0C, 32'h0);
        check(resp, `TPM_RESP_SLVERR);
        bus(1'b1, `TPM_STATUS_OFS, d);
        bus(1'b0, `TPM_STATUS_OFS, 32'h0);
        check({resp, rd[1:0]}, 4'h0);
        // Random line states; checker watches squelch
        repeat (100) begin
            @(posedge i_clock);
            line <= 4'($urandom);
        end
        line <= '0;
        settle(LOSS + 20);
        check(oe_n, 1'b1);
        line <= 4'h2;
        settle(1);
        line <= 4'h0;
        settle(4);
        check({link, oe_n}, 2'h0);
        line <= 4'h5;
        settle(4);
        check({link, oe_n}, 2'h2);
        {line, tx_en} <= {4'h4, 1'b1};
        settle(6);
        check({coll, drv}, 2'h3);
        tx_en <= 1'b0;
        settle(300);
        {fd_req, tx_en} <= 2'h3;
        settle(6);
        check({coll, drv}, 2'h1);
        tx_en <= 1'b0;
        settle(270);
        {fd_req, line} <= '0;
        {loop_req, tx_en} <= 2'h3;
        repeat (4) begin
            tx_dat <= 1'($urandom);
            settle(4);
            check({drv, rxo, txd}, {1'b0, tx_dat, tx_dat});
        end
        bus(1'b0, `TPM_STATUS_OFS, 32'h0);
        check(rd[1:0], 2'h1);
        {loop_req, tx_en} <= 2'h0;
        settle(4);
        tx_en <= 1'b1;
        settle(JAB + JOFF + 20);
        check({jab, drv}, 2'h2);
        tx_en <= 1'b0;
        settle(JOFF + 10);
        check(jab, 1'b0);
        // Wrong order: full duplex before loop-back gives no entry
        fd_req <= 1'b1;
        settle(3);
        loop_req <= 1'b1;
        settle(10);
        check(n_rst, 0);
        {fd_req, loop_req} <= 2'h0;
        settle(3);
        // Ones shifted in on the quality pin as the test pattern
        {qual_n, test_req} <= 2'h3;
        for (int k = 0; k < 20 && n_rst == 0; k++) settle(1);
        check(n_rst, 1);
        settle(300);
        bus(1'b0, `TPM_STATUS_OFS, 32'h0);
        check(rd[1:0], 2'h2);
        bus(1'b0, `TPM_TEST_OFS, 32'h0);
        check(rd, 32'hFF);
        test_req <= 1'b0;
        settle(3);
        bus(1'b0, `TPM_STATUS_OFS, 32'h0);
        check(rd[1:0], 2'h0);
        test_done();
    end
endmodule : tpm_mode_status_bench
